// File: core/dither_cell.sv
// One frame duty modulator: turns a 4-bit level and a phase seed into an on/off dot.
module dither_cell #(
   parameter int SEED_W = 16
) (
   input wire logic [3:0] level,
   input wire logic [SEED_W-1:0] seed,
   output logic dot_on
);

   logic [2:0] num;
   logic [2:0] den;
   logic [2:0] phase;
   logic [5:0] lo;
   logic [5:0] hi;

   // Spreads the on-frames evenly over the period: a frame is on when the running share steps up.
   always_comb
   begin
      num = stn_pkg::DUTY_ON[level];
      den = stn_pkg::DUTY_PERIOD[level];
      phase = 3'(seed % SEED_W'(den));
      lo = ({3'h0, phase} * {3'h0, num}) / {3'h0, den};
      hi = (({3'h0, phase} + 6'h01) * {3'h0, num}) / {3'h0, den};
      dot_on = (hi != lo);
   end

endmodule : dither_cell

// File: core/stn_pixel_out.sv
// Pixel lookup, frame duty dithering and panel data shifting with an AHB-Lite register slave.
// Operation
// R1 - Gray modes of two and four bits
// R2 - Two-bit gray indexes blue table nibbles
// R3 - Four-bit gray used directly, no lookup
// R4 - 256-colour pixel splits into 3/3/2 components
// R5 - Red component mapped through red table nibbles
// R6 - Green component mapped through green table nibbles
// R7 - Blue component mapped through four blue nibbles
// R8 - 4096-colour nibbles bypass all tables
// R9 - Non-mono levels pass through duty modulation
// R10 - Levels 8 to 15 get listed on-fractions
// R11 - Levels 0 to 7 fractions; zero always off
// R12 - Neighbour dots vary phase every frame
// R13 - Dual scan drives upper and lower together
// R14 - Dual frame ends after both halves done
// R15 - Four-bit single uses low lines only
// R16 - Eight-bit single uses all eight lines
// R17 - Mono skips lookup and modulation entirely
// R18 - Byte bits 7:5 red, 4:2 green, 1:0 blue
// R19 - Latch pulse after each complete line
// R20 - Pattern free; average duty and phase offsets
//
// Added by the designer: the address map and the AHB-Lite interface to the registers.
module stn_pixel_out #(
   parameter int SHIFT_W = 11,
   parameter int LINE_W = 10
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic pix_valid,
   input wire logic [31:0] pix_upper,
   input wire logic [31:0] pix_lower,
   output logic pix_ready,
   input wire logic pixel_shift_clock,
   output logic [7:0] panel_data_lines,
   output logic line_latch_pulse
);

   if (SHIFT_W < 1 || SHIFT_W > 16 || LINE_W < 1 || LINE_W > 16)
   begin : g_bad_width
      $error("stn_pixel_out: SHIFT_W and LINE_W must lie between 1 and 16");
   end

   logic [31:0] ctrl_q;
   logic [31:0] geom_q;
   logic [31:0] red_q;
   logic [31:0] green_q;
   logic [15:0] blue_q;
   logic underrun_q;
   logic [15:0] frame_cnt_q;
   logic [8:0] frame_phase_q;
   logic wr_q;
   logic [7:0] waddr_q;
   logic [31:0] hrdata_q;
   logic hreadyout_q;
   logic [31:0] rd_data;
   logic acc;
   logic sclk_s1_q;
   logic sclk_s2_q;
   logic sclk_s3_q;
   logic fall;
   logic en;
   stn_pkg::pix_mode_e mode;
   stn_pkg::scan_e scan;
   logic [SHIFT_W-1:0] hoz;
   logic [LINE_W-1:0] lines;
   logic [SHIFT_W-1:0] shift_idx_q;
   logic [LINE_W-1:0] line_q;
   logic latch_q;
   logic [7:0] panel_q;
   logic pix_ready_q;
   logic [5:0] cnt_q;
   logic [5:0] cnt_d;
   logic [5:0] need;
   logic [5:0] wdots;
   logic load;
   logic shift_fire;
   stn_pkg::stage_t stage_up_q;
   stn_pkg::stage_t stage_lo_q;
   stn_pkg::stage_t stage_up_d;
   stn_pkg::stage_t stage_lo_d;
   stn_pkg::word_dots_t dots_up;
   stn_pkg::word_dots_t dots_lo;
   logic [7:0][3:0] cell_level;
   logic [7:0][15:0] cell_seed;
   logic [7:0] cell_on;
   logic [7:0] cell_bit;
   logic [7:0] out_word;

   // Expands one buffered word into per-dot 4-bit levels, first dot in slot 0.
   function automatic stn_pkg::word_dots_t unpack_word(input logic [31:0] w, input stn_pkg::pix_mode_e m,
      input logic [31:0] rt, input logic [31:0] gt, input logic [15:0] bt);
      stn_pkg::word_dots_t d;
      logic [7:0] b;
      d = '0;
      b = 8'h00;
      for (int i = 0; i < stn_pkg::DOTS_PER_WORD; i++)
      begin
         case (m)
            stn_pkg::MODE_GRAY2:
               if (i < 16)
                  d[i] = bt[4 * int'(2'(w >> (30 - 2 * i))) +: 4]; // see R2
            stn_pkg::MODE_GRAY4, stn_pkg::MODE_COLOR4096:
               if (i < 8)
                  d[i] = 4'(w >> (28 - 4 * i)); // see R3 see R8
            stn_pkg::MODE_COLOR256:
               if (i < 12)
               begin
                  b = 8'(w >> (24 - 8 * (i / 3))); // see R4
                  case (i % 3)
                     0: d[i] = rt[4 * b[7:5] +: 4]; // see R5 see R18
                     1: d[i] = gt[4 * b[4:2] +: 4]; // see R6 see R18
                     default: d[i] = bt[4 * b[1:0] +: 4]; // see R7 see R18
                  endcase
               end
            default:
               d[i] = {4{w[31 - i]}}; // see R17
         endcase
      end
      return d;
   endfunction : unpack_word

   // Register fields steering the datapath; the mode set covers both gray depths.
   assign en = ctrl_q[stn_pkg::CTRL_EN_BIT];
   assign mode = stn_pkg::pix_mode_e'(ctrl_q[stn_pkg::CTRL_MODE_LSB +: 3]); // see R1
   assign scan = stn_pkg::scan_e'(ctrl_q[stn_pkg::CTRL_SCAN_LSB +: 2]);
   assign hoz = geom_q[stn_pkg::GEOM_SHIFTS_LSB +: SHIFT_W];
   assign lines = geom_q[stn_pkg::GEOM_LINES_LSB +: LINE_W];
   assign acc = hsel & hready & htrans[1];

   // Outputs come straight from flip-flops, except hresp, which is tied low.
   assign hrdata = hrdata_q;
   assign hreadyout = hreadyout_q;
   assign hresp = 1'b0;
   assign pix_ready = pix_ready_q;
   assign panel_data_lines = panel_q;
   assign line_latch_pulse = latch_q;

   // Read multiplexer for the address phase; unmapped offsets read zero.
   always_comb
   begin
      case (haddr[7:0])
         stn_pkg::CTRL_OFF: rd_data = ctrl_q;
         stn_pkg::GEOM_OFF: rd_data = geom_q;
         stn_pkg::RED_OFF: rd_data = red_q;
         stn_pkg::GREEN_OFF: rd_data = green_q;
         stn_pkg::BLUE_OFF: rd_data = {16'h0000, blue_q};
         stn_pkg::STAT_OFF: rd_data = {15'h0000, underrun_q, frame_cnt_q};
         default: rd_data = 32'h0000_0000;
      endcase
   end

   // Address phase capture; reads are answered in the following data phase with no wait state.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_q <= 1'b0;
         waddr_q <= 8'h00;
         hrdata_q <= 32'h0000_0000;
         hreadyout_q <= 1'b1;
      end
      else
      begin
         wr_q <= acc & hwrite;
         waddr_q <= haddr[7:0];
         hrdata_q <= (acc & ~hwrite) ? rd_data : 32'h0000_0000;
         hreadyout_q <= 1'b1;
      end
   end

   // Data phase register writes.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl_q <= stn_pkg::CTRL_RESET;
         geom_q <= stn_pkg::GEOM_RESET;
         red_q <= stn_pkg::RED_RESET;
         green_q <= stn_pkg::GREEN_RESET;
         blue_q <= stn_pkg::BLUE_RESET;
      end
      else if (wr_q)
      begin
         case (waddr_q)
            stn_pkg::CTRL_OFF: ctrl_q <= {26'h0, hwdata[5:0]};
            stn_pkg::GEOM_OFF: geom_q <= hwdata;
            stn_pkg::RED_OFF: red_q <= hwdata;
            stn_pkg::GREEN_OFF: green_q <= hwdata;
            stn_pkg::BLUE_OFF: blue_q <= hwdata[15:0];
            default: ;
         endcase
      end
   end

   // Two-stage synchroniser and falling edge detector on the panel shift clock.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sclk_s1_q <= 1'b0;
         sclk_s2_q <= 1'b0;
         sclk_s3_q <= 1'b0;
      end
      else
      begin
         sclk_s1_q <= pixel_shift_clock;
         sclk_s2_q <= sclk_s1_q;
         sclk_s3_q <= sclk_s2_q;
      end
   end
   assign fall = sclk_s3_q & ~sclk_s2_q;

   // Dots per shift on each lane, dots per word, and the shift and load strobes.
   assign need = (scan == stn_pkg::SCAN_SINGLE8) ? 6'd8 : 6'd4; // see R16
   always_comb
   begin
      case (mode)
         stn_pkg::MODE_GRAY2: wdots = 6'd16;
         stn_pkg::MODE_GRAY4, stn_pkg::MODE_COLOR4096: wdots = 6'd8;
         stn_pkg::MODE_COLOR256: wdots = 6'd12;
         default: wdots = 6'd32;
      endcase
   end
   assign load = pix_valid & pix_ready_q;
   assign shift_fire = fall & en & ~latch_q & (cnt_q >= need);
   assign dots_up = unpack_word(pix_upper, mode, red_q, green_q, blue_q);
   assign dots_lo = unpack_word(pix_lower, mode, red_q, green_q, blue_q);

   // Staging queues: consume the shifted dots, then append a new word behind the rest.
   always_comb
   begin
      int cons;
      int base;
      cons = shift_fire ? int'(need) : 0;
      base = int'(cnt_q) - cons;
      stage_up_d = '0;
      stage_lo_d = '0;
      for (int i = 0; i < stn_pkg::STAGE_DOTS; i++)
      begin
         if (i < base)
         begin
            stage_up_d[i] = stage_up_q[i + cons];
            stage_lo_d[i] = stage_lo_q[i + cons];
         end
         else if (load && i - base < stn_pkg::DOTS_PER_WORD)
         begin
            stage_up_d[i] = dots_up[i - base];
            stage_lo_d[i] = dots_lo[i - base];
         end
      end
      cnt_d = 6'(base) + (load ? wdots : 6'd0);
      if (!en)
         cnt_d = 6'd0;
   end

   // Staging storage and source handshake; ready only while a shift's worth is missing.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         stage_up_q <= '0;
         stage_lo_q <= '0;
         cnt_q <= 6'd0;
         pix_ready_q <= 1'b0;
      end
      else
      begin
         stage_up_q <= stage_up_d;
         stage_lo_q <= stage_lo_d;
         cnt_q <= cnt_d;
         pix_ready_q <= en & (cnt_d < need);
      end
   end

   // Cell inputs: dual scan feeds cells 0-3 from the upper queue and 4-7 from the lower queue.
   always_comb
   begin
      for (int k = 0; k < 8; k++)
      begin
         int kk;
         kk = (scan == stn_pkg::SCAN_DUAL4) ? (k % 4) : k;
         if (scan == stn_pkg::SCAN_DUAL4 && k >= 4)
            cell_level[k] = stage_lo_q[k - 4]; // see R13
         else
            cell_level[k] = stage_up_q[k];
         cell_seed[k] = 16'(frame_phase_q) + 16'(line_q) + 16'(shift_idx_q) * 16'(need) + 16'(kk); // see R12 see R20
      end
   end

   // Eight duty modulators, one per data line.
   for (genvar k = 0; k < 8; k++)
   begin : g_cell
      dither_cell #(
         .SEED_W(16)
      ) u_cell (
         .level(cell_level[k]),
         .seed(cell_seed[k]),
         .dot_on(cell_on[k])
      );
   end

   // Mono dots bypass modulation; the first dot of each shift sits on the highest line of its lane.
   always_comb
   begin
      for (int k = 0; k < 8; k++)
         cell_bit[k] = (mode == stn_pkg::MODE_MONO) ? cell_level[k][3] : cell_on[k]; // see R9 see R17
      if (scan == stn_pkg::SCAN_SINGLE4)
         out_word = {4'h0, cell_bit[0], cell_bit[1], cell_bit[2], cell_bit[3]}; // see R15
      else
      begin
         for (int k = 0; k < 8; k++)
            out_word[7 - k] = cell_bit[k]; // see R13 see R16
      end
   end

   // Data lines change on the falling shift clock edge so the driver captures them on the rising one.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         panel_q <= 8'h00;
      else if (!en)
         panel_q <= 8'h00;
      else if (shift_fire)
         panel_q <= out_word; // see R19
   end

   // Line and frame position; the latch pulse fills one shift slot after a line's last shift.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         shift_idx_q <= '0;
         line_q <= '0;
         latch_q <= 1'b0;
         frame_cnt_q <= 16'h0000;
         frame_phase_q <= 9'h000;
      end
      else if (!en)
      begin
         shift_idx_q <= '0;
         line_q <= '0;
         latch_q <= 1'b0;
      end
      else if (fall && latch_q)
         latch_q <= 1'b0;
      else if (shift_fire)
      begin
         if (shift_idx_q == hoz)
         begin
            shift_idx_q <= '0;
            latch_q <= 1'b1; // see R19
            if (line_q == lines)
            begin
               line_q <= '0; // see R14
               frame_cnt_q <= frame_cnt_q + 16'h0001;
               frame_phase_q <= (frame_phase_q == stn_pkg::FRAME_PHASE_LAST) ? 9'h000 : frame_phase_q + 9'h001;
            end
            else
               line_q <= line_q + 1'b1;
         end
         else
            shift_idx_q <= shift_idx_q + 1'b1;
      end
   end

   // Sticky underrun: a shift slot with too few dots; write one to clear, a new event wins.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         underrun_q <= 1'b0;
      else if (fall && en && !latch_q && cnt_q < need)
         underrun_q <= 1'b1;
      else if (wr_q && waddr_q == stn_pkg::STAT_OFF && hwdata[stn_pkg::STAT_UNDERRUN_BIT])
         underrun_q <= 1'b0;
   end

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_gray2_blue_nibble: assert property ( // see R2
      load && !shift_fire && cnt_q == 6'd0 && mode == stn_pkg::MODE_GRAY2
      |=> stage_up_q[0] == blue_q[{$past(pix_upper[31:30]), 2'b00} +: 4])
      else $error("gray2 dot not taken from blue table");
   a_gray4_direct_level: assert property ( // see R3
      load && !shift_fire && cnt_q == 6'd0 && mode == stn_pkg::MODE_GRAY4
      |=> stage_up_q[1] == $past(pix_upper[27:24]))
      else $error("gray4 dot not passed directly");
   a_red_byte_field: assert property ( // see R18
      load && !shift_fire && cnt_q == 6'd0 && mode == stn_pkg::MODE_COLOR256
      |=> stage_up_q[0] == red_q[{$past(pix_upper[31:29]), 2'b00} +: 4])
      else $error("red dot not taken from red table");
   a_blue_byte_field: assert property ( // see R7
      load && !shift_fire && cnt_q == 6'd0 && mode == stn_pkg::MODE_COLOR256
      |=> stage_up_q[2] == blue_q[{$past(pix_upper[25:24]), 2'b00} +: 4])
      else $error("blue dot not taken from blue table");
   a_color4096_bypass: assert property ( // see R8
      load && !shift_fire && cnt_q == 6'd0 && mode == stn_pkg::MODE_COLOR4096
      |=> stage_up_q[2] == $past(pix_upper[23:20]))
      else $error("4096 colour nibble altered");
   a_level15_always_on: assert property ( // see R10
      shift_fire && mode != stn_pkg::MODE_MONO && scan == stn_pkg::SCAN_SINGLE4 && stage_up_q[0] == 4'hF
      |=> panel_q[3])
      else $error("level 15 dot not on");
   a_level0_always_off: assert property ( // see R11
      shift_fire && mode != stn_pkg::MODE_MONO && scan == stn_pkg::SCAN_SINGLE4 && stage_up_q[0] == 4'h0
      |=> !panel_q[3])
      else $error("level 0 dot not off");
   a_single4_upper_idle: assert property ( // see R15
      shift_fire && scan == stn_pkg::SCAN_SINGLE4 |=> panel_q[7:4] == 4'h0)
      else $error("upper lines driven in 4-bit single scan");
   a_mono_raw_bits: assert property ( // see R17
      shift_fire && mode == stn_pkg::MODE_MONO && scan == stn_pkg::SCAN_SINGLE8
      |=> panel_q[7] == $past(stage_up_q[0][3]) && panel_q[0] == $past(stage_up_q[7][3]))
      else $error("mono bits not serialised directly");
   a_dual_lower_lane: assert property ( // see R13
      shift_fire && mode == stn_pkg::MODE_MONO && scan == stn_pkg::SCAN_DUAL4
      |=> panel_q[3] == $past(stage_lo_q[0][3]) && panel_q[7] == $past(stage_up_q[0][3]))
      else $error("dual scan lanes not shifted together");
   a_latch_after_line: assert property ( // see R19
      $rose(latch_q) |-> $past(shift_fire && shift_idx_q == hoz))
      else $error("latch pulse not after last shift of line");
   a_frame_after_half: assert property ( // see R14
      frame_cnt_q != $past(frame_cnt_q) |-> $past(line_q == lines && latch_q == 1'b0) ##1 latch_q)
      else $error("frame ended before last line");

endmodule : stn_pixel_out

// File: core/stn_pkg.sv
// Shared constants, types and register map of the passive-matrix pixel output path.
package stn_pkg;

   // Register byte offsets inside the slave window.
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] GEOM_OFF = 8'h04;
   localparam logic [7:0] RED_OFF = 8'h08;
   localparam logic [7:0] GREEN_OFF = 8'h0C;
   localparam logic [7:0] BLUE_OFF = 8'h10;
   localparam logic [7:0] STAT_OFF = 8'h14;

   // Field positions.
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_MODE_LSB = 1;
   localparam int CTRL_SCAN_LSB = 4;
   localparam int GEOM_SHIFTS_LSB = 0;
   localparam int GEOM_LINES_LSB = 16;
   localparam int STAT_UNDERRUN_BIT = 16;

   // Reset values.
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] GEOM_RESET = 32'h0000_0000;
   localparam logic [31:0] RED_RESET = 32'hFDB8_6420;
   localparam logic [31:0] GREEN_RESET = 32'hFDB8_6420;
   localparam logic [15:0] BLUE_RESET = 16'hFA50;

   // Staging geometry and frame phase period (least common multiple of duty periods 1 to 7).
   localparam int DOTS_PER_WORD = 32;
   localparam int STAGE_DOTS = 40;
   localparam logic [8:0] FRAME_PHASE_LAST = 9'h1A3;

   typedef enum logic [2:0] {MODE_MONO, MODE_GRAY2, MODE_GRAY4, MODE_COLOR256, MODE_COLOR4096} pix_mode_e;
   typedef enum logic [1:0] {SCAN_DUAL4, SCAN_SINGLE4, SCAN_SINGLE8} scan_e;
   typedef logic [DOTS_PER_WORD-1:0][3:0] word_dots_t;
   typedef logic [STAGE_DOTS-1:0][3:0] stage_t;

   // On-frames and period of each 4-bit level.
   localparam logic [2:0] DUTY_ON [0:15] = '{3'h0, 3'h1, 3'h1, 3'h1, 3'h1, 3'h2, 3'h3, 3'h1,
                                             3'h4, 3'h3, 3'h2, 3'h5, 3'h3, 3'h4, 3'h6, 3'h1};
   localparam logic [2:0] DUTY_PERIOD [0:15] = '{3'h1, 3'h7, 3'h5, 3'h4, 3'h3, 3'h5, 3'h7, 3'h2,
                                                 3'h7, 3'h5, 3'h3, 3'h7, 3'h4, 3'h5, 3'h7, 3'h1};

endpackage : stn_pkg

// File: test/panel_model.sv
// Behavioural panel driver that makes the shift clock and captures the data lines.
module panel_model (
   output logic pixel_shift_clock,
   input wire logic run,
   input wire logic [7:0] panel_data_lines,
   input wire logic line_latch_pulse
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] cap_q [$];
   int latch_cnt;
   logic prev_latch;

   // The clock idles high between bursts; a slot after a latch carries no new data.
   initial
   begin
      pixel_shift_clock = 1'b1;
      latch_cnt = 0;
      prev_latch = 1'b0;
      #3;
      forever
      begin
         wait (run === 1'b1);
         #80 pixel_shift_clock = 1'b0;
         #80 pixel_shift_clock = 1'b1;
         if (prev_latch !== 1'b1) cap_q.push_back(panel_data_lines);
         if (line_latch_pulse === 1'b1) latch_cnt++;
         prev_latch = line_latch_pulse;
      end
   end
endmodule : panel_model

// File: test/tb_stn_pixel_out.sv
// Self-checking bench for the passive-matrix pixel output path.
module tb_stn_pixel_out;
   timeunit 1ns;
   timeprecision 100ps;
   logic hclk, hresetn, hsel, hwrite, hready, pix_valid, run;
   logic [31:0] haddr, hwdata, pix_upper, pix_lower, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic hreadyout, hresp, pix_ready, pixel_shift_clock, line_latch_pulse;
   logic [7:0] panel_data_lines;
   int err_count, n_tests;

   // The single slave's ready is the bus ready.
   assign hready = hreadyout;

   stn_pixel_out dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .pix_valid(pix_valid), .pix_upper(pix_upper),
      .pix_lower(pix_lower), .pix_ready(pix_ready), .pixel_shift_clock(pixel_shift_clock),
      .panel_data_lines(panel_data_lines), .line_latch_pulse(line_latch_pulse));

   panel_model panel (.pixel_shift_clock(pixel_shift_clock), .run(run),
      .panel_data_lines(panel_data_lines), .line_latch_pulse(line_latch_pulse));

   // System clock of 10 ns.
   initial
   begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   task automatic print_verdict;
      if (err_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : print_verdict

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // One single word transfer; address phase held until ready, data taken at the closing edge.
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
      haddr <= {24'h00_0000, a};
      htrans <= 2'b10;
      hwrite <= wr;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask : bus

   task automatic wr32(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] unused;
      bus(1'b1, a, d, unused);
   endtask : wr32

   task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] got;
      bus(1'b0, a, 32'h0000_0000, got);
      chk(what, exp, got);
   endtask : rd_chk

   function automatic logic [31:0] cfg(input stn_pkg::pix_mode_e m, input stn_pkg::scan_e s);
      return {26'h000_0000, s, m, 1'b1};
   endfunction : cfg

   // Restarts the path with a new setup and collects n captured shifts.
   task automatic shift_run(input logic [31:0] ctrl, input int shifts, input logic [31:0] up, input logic [31:0] lo,
      input int n);
      wr32(stn_pkg::CTRL_OFF, 32'h0000_0000);
      wr32(stn_pkg::GEOM_OFF, 32'(shifts - 1));
      pix_upper <= up;
      pix_lower <= lo;
      panel.cap_q.delete();
      panel.latch_cnt = 0;
      panel.prev_latch = 1'b0;
      wr32(stn_pkg::CTRL_OFF, ctrl);
      run <= 1'b1;
      for (int i = 0; i < 20000 && panel.cap_q.size() < n; i++) @(posedge hclk);
      run <= 1'b0;
      chk("capture count", 32'(n), 32'(panel.cap_q.size() >= n ? n : panel.cap_q.size()));
      repeat (30) @(posedge hclk);
   endtask : shift_run

   task automatic t_regs;
      rd_chk("ctrl reset", stn_pkg::CTRL_OFF, 32'h0000_0000);
      rd_chk("geom reset", stn_pkg::GEOM_OFF, 32'h0000_0000);
      rd_chk("red_level_table reset", stn_pkg::RED_OFF, 32'hFDB8_6420);
      rd_chk("green_level_table reset", stn_pkg::GREEN_OFF, 32'hFDB8_6420);
      rd_chk("blue_gray_level_table reset", stn_pkg::BLUE_OFF, 32'h0000_FA50);
      rd_chk("status reset", stn_pkg::STAT_OFF, 32'h0000_0000);
      chk("hresp", 32'h0, {31'h0, hresp});
      chk("pix_ready disabled", 32'h0, {31'h0, pix_ready});
      wr32(stn_pkg::RED_OFF, 32'h1234_5678);
      rd_chk("red_level_table", stn_pkg::RED_OFF, 32'h1234_5678);
      wr32(8'h20, 32'hFFFF_FFFF);
      rd_chk("unmapped", 8'h20, 32'h0000_0000);
   endtask : t_regs

   task automatic t_mono8;
      shift_run(cfg(stn_pkg::MODE_MONO, stn_pkg::SCAN_SINGLE8), 4, 32'hA5C3_0FF1, 32'h0, 8);
      for (int i = 0; i < 8; i++) chk("mono single8", {24'h0, 8'(32'hA5C3_0FF1 >> (24 - 8 * (i % 4)))},
         {24'h0, panel.cap_q[i]});
      chk("latch count", 32'd2, 32'(panel.latch_cnt));
      rd_chk("frame count", stn_pkg::STAT_OFF, 32'h0000_0002);
   endtask : t_mono8

   task automatic t_mono4;
      shift_run(cfg(stn_pkg::MODE_MONO, stn_pkg::SCAN_SINGLE4), 8, 32'hA5C3_0FF1, 32'h0, 8);
      for (int i = 0; i < 8; i++) chk("mono single4", {28'h0, 4'(32'hA5C3_0FF1 >> (28 - 4 * i))},
         {24'h0, panel.cap_q[i]});
   endtask : t_mono4

   task automatic t_mono_dual;
      shift_run(cfg(stn_pkg::MODE_MONO, stn_pkg::SCAN_DUAL4), 8, 32'hA5C3_0FF1, 32'h1234_5678, 8);
      for (int i = 0; i < 8; i++) chk("mono dual", {24'h0, 4'(32'hA5C3_0FF1 >> (28 - 4 * i)),
         4'(32'h1234_5678 >> (28 - 4 * i))}, {24'h0, panel.cap_q[i]});
   endtask : t_mono_dual

   task automatic t_gray2;
      wr32(stn_pkg::BLUE_OFF, 32'h0000_F00F);
      shift_run(cfg(stn_pkg::MODE_GRAY2, stn_pkg::SCAN_SINGLE8), 4, 32'h1B1B_1B1B, 32'h0, 4);
      for (int i = 0; i < 4; i++) chk("gray2 lookup", 32'h99, {24'h0, panel.cap_q[i]});
   endtask : t_gray2

   task automatic t_gray4;
      shift_run(cfg(stn_pkg::MODE_GRAY4, stn_pkg::SCAN_SINGLE8), 4, 32'hF0F0_F0F0, 32'h0, 4);
      for (int i = 0; i < 4; i++) chk("gray4 direct", 32'hAA, {24'h0, panel.cap_q[i]});
   endtask : t_gray4

   task automatic t_c256;
      wr32(stn_pkg::RED_OFF, 32'hF000_0000);
      wr32(stn_pkg::GREEN_OFF, 32'h0000_000F);
      wr32(stn_pkg::BLUE_OFF, 32'h0000_0F00);
      shift_run(cfg(stn_pkg::MODE_COLOR256, stn_pkg::SCAN_SINGLE8), 6, 32'hE21D_E21D, 32'h0, 6);
      for (int i = 0; i < 6; i++) chk("c256 lookup", i % 3 == 0 ? 32'hE3 : (i % 3 == 1 ? 32'h8E : 32'h38),
         {24'h0, panel.cap_q[i]});
      chk("latch count", 32'd1, 32'(panel.latch_cnt));
   endtask : t_c256

   task automatic t_c4096;
      shift_run(cfg(stn_pkg::MODE_COLOR4096, stn_pkg::SCAN_SINGLE8), 3, 32'hF0F0_F0F0, 32'h0, 3);
      for (int i = 0; i < 3; i++) chk("c4096 bypass", 32'hAA, {24'h0, panel.cap_q[i]});
   endtask : t_c4096

   task automatic t_duty;
      logic [7:0] b;
      shift_run(cfg(stn_pkg::MODE_GRAY4, stn_pkg::SCAN_SINGLE4), 8, 32'h7777_7777, 32'h0, 8);
      for (int i = 0; i < 8; i++)
      begin
         b = panel.cap_q[i];
         chk("half duty lanes", 32'd2, 32'($countones(b[3:0])));
         chk("neighbour phase", 32'd1, {31'h0, b[0] ^ b[1]});
         chk("upper lines idle", 32'h0, {28'h0, b[7:4]});
      end
   endtask : t_duty

   // Main sequence: reset for 12 cycles, then every scenario in turn.
   initial
   begin
      err_count = 0;
      n_tests = 0;
      hresetn = 1'b0;
      hsel = 1'b0;
      hwrite = 1'b0;
      haddr = 32'h0000_0000;
      hwdata = 32'h0000_0000;
      htrans = 2'b00;
      hsize = 3'b010;
      pix_valid = 1'b0;
      pix_upper = 32'h0000_0000;
      pix_lower = 32'h0000_0000;
      run = 1'b0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      hsel <= 1'b1;
      pix_valid <= 1'b1;
      t_regs();
      t_mono8();
      t_mono4();
      t_mono_dual();
      t_gray2();
      t_gray4();
      t_c256();
      t_c4096();
      t_duty();
      print_verdict();
   end

   // Watchdog well beyond the expected run of some 12 us.
   initial
   begin
      #400000;
      err_count++;
      print_verdict();
   end
endmodule : tb_stn_pixel_out
